// file: include/serial_glue_pkg.sv
// Constants shared by the serial option glue logic
`default_nettype none
package serial_glue_pkg;
    // Mask latch output positions, chosen by the two low address bits
    localparam logic [1:0] LATCH_RX_MASK   = 2'h0;
    localparam logic [1:0] LATCH_TX_MASK   = 2'h1;
    localparam logic [1:0] LATCH_LINE_CTRL = 2'h2;
    localparam logic [1:0] LATCH_DIAGNOSTIC_LATCH_BIT      = 2'h3;
    localparam logic [3:0] LATCH_RESET     = 4'h0;
    // Primary decoder strobe numbers (address bits 7,6,3)
    localparam logic [2:0] STB_UART   = 3'h0;
    localparam logic [2:0] STB_PARAM  = 3'h1;
    localparam logic [2:0] STB_STATUS = 3'h2;
    localparam logic [2:0] STB_LATCH  = 3'h3;
    // Parameter and status port bit positions
    localparam int PARAM_SDO_BIT   = 7;
    localparam int ST_PWR_BIT      = 0;
    localparam int ST_RX_BIT       = 1;
    localparam int ST_TX_BIT       = 2;
    localparam int ST_SW8_BIT      = 3;
    localparam int ST_SW10_BIT     = 4;
    localparam int ST_SW9_BIT      = 5;
    localparam int ST_DIAGNOSTIC_LATCH_BIT_BIT     = 6;
    localparam int ST_DCD_BIT      = 7;
    // Switch indices (switch position n is index n-1)
    localparam int SW8_IDX  = 7;
    localparam int SW9_IDX  = 8;
    localparam int SW10_IDX = 9;
    // Option RAM image range
    localparam logic [19:0] RAM_BASE = 20'h88000;
    localparam logic [19:0] RAM_TOP  = 20'h8FFFF;
    // Baud divisor reset value
    localparam logic [15:0] BAUD_DIV_RESET = 16'h0001;
endpackage : serial_glue_pkg
`default_nettype wire

// file: hdl/serial_option_glue_logic.sv
// Glue logic of the serial option board: decode, interrupt merge, mask latch, ports
`default_nettype none
module serial_option_glue_logic
    import serial_glue_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Host bus, from pins
    input  wire logic [13:0] bus_addr,
    input  wire logic        io_segment_sel_n,
    input  wire logic        common_segment_sel_n,
    input  wire logic        block_zero_sel_n,
    input  wire logic        block_one_sel_n,
    input  wire logic        block_three_sel_n,
    input  wire logic        option_ram_disable,
    input  wire logic        processor_data_enable_n,
    input  wire logic        bus_rd_n,
    input  wire logic        bus_wr_n,
    input  wire logic [7:0]  bus_data_in,
    input  wire logic        buffered_system_reset,
    // Host bus outputs
    output logic [7:0]       bus_data_out,
    output logic             bus_data_oe,
    output logic             data_buffer_enable_n,
    output logic             option_ram_sel_n,
    output logic [7:0]       decode_strobe_n,
    output logic             uart_sel_n,
    // UART side and board inputs
    input  wire logic        uart_general_irq,
    input  wire logic        rx_data_ready_irq,
    input  wire logic        tx_holding_empty_irq,
    input  wire logic        uart_serial_out,
    input  wire logic        power_failing_irq,
    input  wire logic        carrier_detect_in,
    input  wire logic [9:0]  param_switch,
    input  wire logic [15:0] baud_divisor,
    // Board outputs
    output logic             processor_irq_n,
    output logic             line_signal_control_out,
    output logic             diagnostic_latch_bit,
    output logic             baud_tick
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers: every pin passes two flops before use

    localparam int SW = 14 + 8 + 16 + 10 + 16;
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] sync1_q;
    logic [SW-1:0] sync2_q;

    // Sync flops reset to idle pin levels so no strobe pulses while the chain refills
    localparam logic [SW-1:0] PIN_IDLE = {14'h0000, 5'h1F, 1'b0, 1'b1, 1'b1, 8'h00, 1'b1,
                                          1'b0, 6'h00, 10'h000, 16'h0000};

    assign pin_raw = {bus_addr, io_segment_sel_n, common_segment_sel_n, block_zero_sel_n,
                      block_one_sel_n, block_three_sel_n, option_ram_disable,
                      processor_data_enable_n, bus_rd_n, bus_data_in,
                      bus_wr_n, buffered_system_reset, uart_general_irq, rx_data_ready_irq,
                      tx_holding_empty_irq, uart_serial_out, power_failing_irq,
                      carrier_detect_in, param_switch, baud_divisor};

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= PIN_IDLE;
            sync2_q <= PIN_IDLE;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    logic [13:0] addr_s;
    logic        io_seg_n_s;
    logic        common_segment_sel_n_n_s;
    logic        block_zero_sel_n_n_s;
    logic        block_one_sel_n_n_s;
    logic        block_three_sel_n_n_s;
    logic        option_ram_disable_s;
    logic        den_n_s;
    logic        rd_n_s;
    logic [7:0]  din_s;
    logic        wr_n_s;
    logic        buffered_system_reset_s;
    logic        gen_irq_s;
    logic        rdy_irq_s;
    logic        tx_irq_s;
    logic        sdo_s;
    logic        pwr_s;
    logic        dcd_s;
    logic [9:0]  sw_s;
    logic [15:0] div_s;

    assign {addr_s, io_seg_n_s, common_segment_sel_n_n_s, block_zero_sel_n_n_s, block_one_sel_n_n_s, block_three_sel_n_n_s, option_ram_disable_s,
            den_n_s, rd_n_s, din_s, wr_n_s, buffered_system_reset_s, gen_irq_s, rdy_irq_s, tx_irq_s,
            sdo_s, pwr_s, dcd_s, sw_s, div_s} = sync2_q;

////////////////////////////////////////////////////////////////////////////////
// Address decode

    function automatic logic [7:0] one_of_eight(input logic en, input logic [2:0] sel);
        logic [7:0] r;
        r = 8'hFF;
        if (en) begin
            r[sel] = 1'b0;
        end
        return r;
    endfunction : one_of_eight

    logic       decode_en;
    logic [2:0] stb_sel;
    logic [7:0] strobe_n;
    logic       io_port_sel_n;

    always_comb begin
        decode_en = !addr_s[12] && !addr_s[13] && !io_seg_n_s && !block_zero_sel_n_n_s;
        stb_sel   = {addr_s[7], addr_s[6], addr_s[3]};
        strobe_n  = one_of_eight(decode_en, stb_sel);
        // Option I/O decode also needs address bit 8 low
        io_port_sel_n = !(decode_en && !addr_s[8]);
    end

    assign decode_strobe_n      = strobe_n;
    assign uart_sel_n           = strobe_n[STB_UART];
    // Host relies on the top image only; lower images alias harmlessly
    assign option_ram_sel_n     = !(!common_segment_sel_n_n_s && !option_ram_disable_s && !block_three_sel_n_n_s
                                    && block_zero_sel_n_n_s && block_one_sel_n_n_s);
    assign data_buffer_enable_n = !(!den_n_s && (!common_segment_sel_n_n_s || !io_port_sel_n));

////////////////////////////////////////////////////////////////////////////////
// Interrupt mask latch

    logic [3:0] latch_q;
    logic [3:0] latch_d;
    logic       wr_q;
    logic       wr_d;
    logic       latch_wr;

    always_comb begin
        wr_d     = !wr_n_s;
        // Write acts once, on the write line's leading edge while the latch strobe is low
        latch_wr = !wr_n_s && !wr_q && !strobe_n[STB_LATCH];
        latch_d  = latch_q;
        if (buffered_system_reset_s) begin
            latch_d = LATCH_RESET;
        end else if (latch_wr) begin
            latch_d[addr_s[1:0]] = din_s[0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            latch_q <= LATCH_RESET;
            wr_q    <= 1'b0;
        end else begin
            latch_q <= latch_d;
            wr_q    <= wr_d;
        end
    end

    assign line_signal_control_out = latch_q[LATCH_LINE_CTRL];
    assign diagnostic_latch_bit    = latch_q[LATCH_DIAGNOSTIC_LATCH_BIT];

////////////////////////////////////////////////////////////////////////////////
// Interrupt merge

    logic combined_rx_irq;
    logic combined_rx_irq_mask;
    logic tx_empty_irq_mask;
    logic irq_n_q;
    logic irq_n_d;

    always_comb begin
        combined_rx_irq      = gen_irq_s | rdy_irq_s;
        combined_rx_irq_mask = latch_q[LATCH_RX_MASK];
        tx_empty_irq_mask    = latch_q[LATCH_TX_MASK];
        // Active low, held while any unmasked request persists
        irq_n_d = !((combined_rx_irq & combined_rx_irq_mask)
                    | (tx_irq_s & tx_empty_irq_mask));
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= irq_n_d;
        end
    end

    assign processor_irq_n = irq_n_q;

////////////////////////////////////////////////////////////////////////////////
// Read ports

    logic [7:0] dout_q;
    logic [7:0] dout_d;
    logic       oe_q;
    logic       oe_d;

    always_comb begin
        dout_d = 8'h00;
        oe_d   = 1'b0;
        if (!rd_n_s && !strobe_n[STB_PARAM]) begin
            oe_d   = 1'b1;
            dout_d = sw_s[7:0];
            dout_d[PARAM_SDO_BIT] = sdo_s;
        end else if (!rd_n_s && !strobe_n[STB_STATUS]) begin
            oe_d = 1'b1;
            dout_d[ST_PWR_BIT]  = pwr_s;
            dout_d[ST_RX_BIT]   = combined_rx_irq;
            dout_d[ST_TX_BIT]   = tx_irq_s;
            dout_d[ST_SW8_BIT]  = sw_s[SW8_IDX];
            dout_d[ST_SW10_BIT] = sw_s[SW10_IDX];
            dout_d[ST_SW9_BIT]  = sw_s[SW9_IDX];
            dout_d[ST_DIAGNOSTIC_LATCH_BIT_BIT] = latch_q[LATCH_DIAGNOSTIC_LATCH_BIT];
            dout_d[ST_DCD_BIT]  = dcd_s;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dout_q <= 8'h00;
            oe_q   <= 1'b0;
        end else begin
            dout_q <= dout_d;
            oe_q   <= oe_d;
        end
    end

    assign bus_data_out = dout_q;
    assign bus_data_oe  = oe_q;

////////////////////////////////////////////////////////////////////////////////
// Baud rate divider; divisor of zero is treated as one to avoid a stuck tick

    logic [15:0] baud_cnt_q;
    logic [15:0] baud_cnt_d;
    logic        tick_q;
    logic        tick_d;
    logic [15:0] div_prev_q;
    logic [15:0] div_prev_d;
    logic [15:0] div_use_q;
    logic [15:0] div_use_d;

    // The divisor is a word crossing from the pins; take it only once it
    // reads the same on two edges in a row, so a word caught mid-change is never used
    always_comb begin
        div_prev_d = div_s;
        div_use_d  = div_use_q;
        if (div_s == div_prev_q) begin
            div_use_d = div_s;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_prev_q <= BAUD_DIV_RESET;
            div_use_q  <= BAUD_DIV_RESET;
        end else begin
            div_prev_q <= div_prev_d;
            div_use_q  <= div_use_d;
        end
    end

    always_comb begin
        tick_d     = 1'b0;
        baud_cnt_d = baud_cnt_q + 16'h0001;
        if (baud_cnt_q + 16'h0001 >= div_use_q) begin
            baud_cnt_d = 16'h0000;
            tick_d     = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            baud_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end else begin
            baud_cnt_q <= baud_cnt_d;
            tick_q     <= tick_d;
        end
    end

    assign baud_tick = tick_q;

endmodule : serial_option_glue_logic
`default_nettype wire

// file: testbench/serial_glue_sva.sv
// Port assertions for the serial option glue logic
`default_nettype none
module serial_glue_sva
    import serial_glue_pkg::*;
(
    input wire logic core_clk, nrst, bus_rd_n, bus_wr_n, buffered_system_reset,
        io_segment_sel_n, common_segment_sel_n, block_zero_sel_n, block_one_sel_n,
        block_three_sel_n, option_ram_disable, processor_data_enable_n, uart_general_irq,
        rx_data_ready_irq, tx_holding_empty_irq, uart_serial_out, bus_data_oe,
        data_buffer_enable_n, option_ram_sel_n, processor_irq_n, line_signal_control_out,
        diagnostic_latch_bit, uart_sel_n,
    input wire logic [13:0] bus_addr,
    input wire logic [9:0]  param_switch,
    input wire logic [7:0]  bus_data_out, decode_strobe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins pass two sync flops, so decodes are compared against values two edges old
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    ram_sel_a: assert property (nrst[*4] |-> option_ram_sel_n ==
        ($past({common_segment_sel_n, option_ram_disable, block_three_sel_n,
        block_zero_sel_n, block_one_sel_n}, 2) != 5'b00011)) else $error("ram select");
    buf_en_a: assert property (nrst[*4] |-> data_buffer_enable_n ==
        !(!$past(processor_data_enable_n, 2) && (!$past(common_segment_sel_n, 2) ||
        $past({bus_addr[13:12], bus_addr[8], io_segment_sel_n, block_zero_sel_n}, 2)
        == 5'h00))) else $error("buffer enable");
    strobe_a: assert property (nrst[*4] |-> decode_strobe_n ==
        ($past({bus_addr[13:12], io_segment_sel_n, block_zero_sel_n}, 2) != 4'h0 ? 8'hFF :
        ~(8'h01 << $past({bus_addr[7:6], bus_addr[3]}, 2)))) else $error("strobe");
    irq_idle_a: assert property ((!(uart_general_irq || rx_data_ready_irq ||
        tx_holding_empty_irq))[*4] |=> processor_irq_n) else $error("irq idle");
    sys_clear_a: assert property (buffered_system_reset[*6] |=>
        !line_signal_control_out && !diagnostic_latch_bit && processor_irq_n)
        else $error("latch clear");
    latch_hold_a: assert property ((bus_wr_n && !buffered_system_reset)[*6] |=>
        $stable(line_signal_control_out) && $stable(diagnostic_latch_bit))
        else $error("latch hold");
    read_idle_a: assert property (bus_rd_n[*5] |=> !bus_data_oe) else $error("oe");
    status_sw_a: assert property (bus_data_oe && $past(bus_addr, 3) == 14'h0040 |->
        bus_data_out[5:3] == $past({param_switch[8], param_switch[9], param_switch[7]}, 3))
        else $error("status switches");
    param_sdo_a: assert property (bus_data_oe && $past(bus_addr, 3) == 14'h0008 |->
        bus_data_out[7] == $past(uart_serial_out, 3)) else $error("param bit 7");
    uart_sel_a: assert property (nrst[*4] |-> uart_sel_n ==
        ($past({bus_addr[13:12], bus_addr[7:6], bus_addr[3], io_segment_sel_n,
        block_zero_sel_n}, 2) != 7'h00)) else $error("uart select");
    read_oe_a: assert property ($past({bus_rd_n, bus_addr[13:12], bus_addr[7:6],
        bus_addr[3], io_segment_sel_n, block_zero_sel_n}, 3) == 8'h08 |-> bus_data_oe)
        else $error("status drive");
endmodule : serial_glue_sva
bind serial_option_glue_logic serial_glue_sva sva_u (.*);
`default_nettype wire

// file: testbench/host_bus_model.sv
// Host processor bus and address decode model
`default_nettype none
module host_bus_model (
    input  wire logic core_clk,
    input  wire logic [7:0] bus_data_out,
    output var logic [13:0] bus_addr,
    output var logic [7:0]  bus_data_in,
    output logic io_segment_sel_n, common_segment_sel_n, block_zero_sel_n, block_one_sel_n,
        block_three_sel_n, option_ram_disable, processor_data_enable_n,
    output var logic bus_rd_n, bus_wr_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // {data enable, common, RAM off, block 3, block 0, block 1, I/O segment}
    logic [6:0] dec = 7'h6F;
    assign {processor_data_enable_n, common_segment_sel_n, option_ram_disable,
        block_three_sel_n, block_zero_sel_n, block_one_sel_n, io_segment_sel_n} = dec;
    initial begin
        bus_addr = 14'h0000;
        bus_data_in = 8'h00;
        {bus_rd_n, bus_wr_n} = 2'h3;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Only block level decodes are driven; RAM image aliasing stays outside
    task automatic set_dec(input logic [6:0] p);
        @(posedge core_clk);
        dec <= p;
        repeat (3) @(posedge core_clk);
    endtask : set_dec
    // One transfer of one data bit or byte, strobes held five edges
    task automatic cyc(input logic [13:0] a, input logic rd, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge core_clk);
        bus_addr <= a;
        bus_data_in <= d;
        dec <= dec & 7'h3A;
        bus_rd_n <= !rd;
        bus_wr_n <= rd;
        repeat (5) @(posedge core_clk);
        q = bus_data_out;
        dec <= dec | 7'h45;
        {bus_rd_n, bus_wr_n} <= 2'h3;
        // Released data lines must not look like a held value
        bus_data_in <= ~d;
        repeat (4) @(posedge core_clk);
    endtask : cyc
endmodule : host_bus_model
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the serial option glue logic
`default_nettype none
module testbench
    import serial_glue_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic buffered_system_reset, uart_general_irq, rx_data_ready_irq, tx_holding_empty_irq;
    logic uart_serial_out, power_failing_irq, carrier_detect_in, bus_rd_n, bus_wr_n;
    logic io_segment_sel_n, common_segment_sel_n, block_zero_sel_n, block_one_sel_n;
    logic block_three_sel_n, option_ram_disable, processor_data_enable_n, bus_data_oe;
    logic data_buffer_enable_n, option_ram_sel_n, uart_sel_n, processor_irq_n, baud_tick;
    logic line_signal_control_out, diagnostic_latch_bit;
    logic [13:0] bus_addr;
    logic [9:0]  param_switch;
    logic [15:0] baud_divisor;
    logic [7:0]  bus_data_in, bus_data_out, decode_strobe_n, q, ex, n_tick;
    int          n_fail = 0;
    int          checks_done = 0;
    serial_option_glue_logic dut_u (.*);
    host_bus_model hb_u (.*);
    always #20 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic ci(input logic e);
        chk("irq_n", {7'h00, e}, {7'h00, processor_irq_n});
    endtask : ci
    task automatic cl(input logic [1:0] e);
        chk("latch", {6'h00, e}, {6'h00, diagnostic_latch_bit, line_signal_control_out});
    endtask : cl
    task automatic lw(input logic [1:0] s, input logic b);
        hb_u.cyc({12'h012, s}, 1'b0, {7'h00, b}, q);
    endtask : lw
    task automatic irqs(input logic [2:0] v);
        @(posedge core_clk);
        {uart_general_irq, rx_data_ready_irq, tx_holding_empty_irq} <= v;
        repeat (5) @(posedge core_clk);
    endtask : irqs
    task automatic end_of_test;
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    // Whole run is about 700 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        end_of_test();
    end
    initial begin
        {buffered_system_reset, uart_general_irq, rx_data_ready_irq, tx_holding_empty_irq} = 4'h0;
        {uart_serial_out, power_failing_irq, carrier_detect_in} = 3'h7;
        param_switch = 10'h2A5;
        baud_divisor = 16'h0004;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        cl(2'h0);
        irqs(3'h4);
        ci(1'b1);
        lw(LATCH_RX_MASK, 1'b1);
        ci(1'b0);
        irqs(3'h2);
        ci(1'b0);
        irqs(3'h1);
        ci(1'b1);
        lw(LATCH_TX_MASK, 1'b1);
        ci(1'b0);
        lw(LATCH_LINE_CTRL, 1'b1);
        lw(LATCH_DIAGNOSTIC_LATCH_BIT, 1'b1);
        cl(2'h3);
        lw(LATCH_LINE_CTRL, 1'b0);
        hb_u.cyc(14'h0008, 1'b0, 8'h01, q);
        cl(2'h2);
        irqs(3'h5);
        hb_u.cyc(14'h0040, 1'b1, 8'h00, q);
        chk("status", {carrier_detect_in, 1'b1, param_switch[8], param_switch[9],
            param_switch[7], 2'h3, power_failing_irq}, q);
        for (int s = 0; s < 2; s++) begin
            uart_serial_out <= s[0];
            hb_u.cyc(14'h0008, 1'b1, 8'h00, q);
            chk("param", {s[0], param_switch[6:0]}, q);
        end
        // Divisor pin is 4, so 40 edges hold exactly 10 ticks
        n_tick = 8'h00;
        repeat (40) begin
            @(posedge core_clk);
            n_tick = n_tick + {7'h00, baud_tick};
        end
        chk("baud", 8'h0A, n_tick);
        hb_u.cyc(14'h0000, 1'b1, 8'h00, q);
        @(posedge core_clk);
        buffered_system_reset <= 1'b1;
        repeat (8) @(posedge core_clk);
        buffered_system_reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        cl(2'h0);
        ci(1'b1);
        for (int i = 0; i < 128; i++) begin
            hb_u.set_dec(i[6:0]);
            ex = (i[2] || i[0] || bus_addr[13:12] != 2'h0) ? 8'hFF :
                ~(8'h01 << {bus_addr[7:6], bus_addr[3]});
            chk("strobe", ex, decode_strobe_n);
            chk("ram_sel", {7'h00, i[5:1] != 5'b00011}, {7'h00, option_ram_sel_n});
            chk("buf_en", {7'h00, !(!i[6] && (!i[5] || (ex != 8'hFF && !bus_addr[8])))},
                {7'h00, data_buffer_enable_n});
        end
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
